// ### rtl/eac_device.sv
// Summary of operation
// RULE1: read strobe loads addressed byte into data
// RULE2: each read stalls core four cycles
// RULE3: no reads or address changes while busy
// RULE4: atomic write timed by 26368 oscillator ticks
// RULE5: software polls write strobe before reading
// RULE6: write: wait, load, arm, then strobe
// RULE7: read: wait, load address, strobe, read
// RULE8: wait for self-programming before writing
// RULE9: keep interrupts out of access sequences
// RULE10: write in progress survives a reset
// RULE11: arm self-clears after four cycles
// RULE12: strobe clears when done; stalls two cycles
// RULE13: mode picks erase-write, erase, write, reserved
// RULE14: ready interrupt high while strobe clear
// RULE15: read strobe is a self-clearing pulse
`timescale 1ns/1ps
module eac_device #(
  parameter int          DEPTH        = eac_pkg::DEPTH,
  parameter int          AW           = eac_pkg::ADDR_W,
  parameter int unsigned ATOMIC_TICKS = eac_pkg::RC_ATOMIC_CYC,
  parameter int unsigned SPLIT_TICKS  = eac_pkg::RC_SPLIT_CYC
) (
  // clock and resets
  input wire logic pclk,
  input wire logic presetn,
  input wire logic por_n,
  // calibrated rc oscillator, one-cycle tick
  input wire logic osc_tick,
  // core-facing register port
  eac_if.dev       io
);
  localparam int TW = eac_pkg::TICK_W;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [AW-1:0] addr_q;
  logic [7:0]    data_q;
  logic          rie_q;
  logic [2:0]    arm_cnt_q;
  logic          arm_q;
  logic [2:0]    stall_cnt_q;
  logic          stall_q;
  logic [7:0]    rdata_q;
  logic          irq_q;
  logic [1:0]    mode_q;
  logic          busy_q;
  logic [TW-1:0] tick_q;
  logic [AW-1:0] op_addr_q;
  logic [7:0]    op_data_q;
  logic [1:0]    op_mode_q;
  logic [7:0]    mem_q [DEPTH];

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic          wr_lo;
  logic          wr_hi;
  logic          wr_dat;
  logic          wr_ctl;
  logic          rd_go;
  logic          wr_go;
  logic          done;
  logic [TW-1:0] tick_lim;
  logic [7:0]    cur_byte;
  logic [7:0]    new_byte;
  logic [7:0]    ctl_view;
  logic [7:0]    rdata_d;
  logic [2:0]    stall_cnt_d;
  logic [2:0]    arm_cnt_d;

  assign wr_lo  = io.io_we & (io.io_addr == eac_pkg::IO_ADDR_LO);
  assign wr_hi  = io.io_we & (io.io_addr == eac_pkg::IO_ADDR_HI);
  assign wr_dat = io.io_we & (io.io_addr == eac_pkg::IO_DATA);
  assign wr_ctl = io.io_we & (io.io_addr == eac_pkg::IO_CTRL);

  assign rd_go  = wr_ctl & io.io_wdata[eac_pkg::CB_RSTB] & ~busy_q; // [RULE3]
  assign wr_go  = wr_ctl & io.io_wdata[eac_pkg::CB_WSTB] & arm_q & ~busy_q
                & (mode_q != eac_pkg::PM_RSVD); // [RULE11] [RULE13]

  // atomic erase-write takes the long count, split steps the short one
  assign tick_lim = (op_mode_q == eac_pkg::PM_ERASE_WRITE) ? TW'(ATOMIC_TICKS - 1)
                                                           : TW'(SPLIT_TICKS - 1); // [RULE4] [RULE13]
  assign done     = busy_q & osc_tick & (tick_q == tick_lim);

  assign cur_byte = mem_q[op_addr_q];
  assign new_byte = (op_mode_q == eac_pkg::PM_ERASE) ? eac_pkg::ERASED_BYTE :
                    (op_mode_q == eac_pkg::PM_WRITE) ? (cur_byte & op_data_q) :
                                                       op_data_q; // [RULE13]

  assign ctl_view = (8'(mode_q) << eac_pkg::CB_PM_LO) | (8'(rie_q) << eac_pkg::CB_RIE)
                  | (8'(arm_q) << eac_pkg::CB_ARM) | (8'(busy_q) << eac_pkg::CB_WSTB);

  assign rdata_d  = (io.io_addr == eac_pkg::IO_ADDR_LO) ? addr_q[7:0] :
                    (io.io_addr == eac_pkg::IO_ADDR_HI) ? 8'(addr_q[AW-1:8]) :
                    (io.io_addr == eac_pkg::IO_DATA)    ? data_q : ctl_view;

  assign stall_cnt_d = rd_go ? 3'(eac_pkg::RD_STALL_CYC) : // [RULE2]
                       wr_go ? 3'(eac_pkg::WR_STALL_CYC) : // [RULE12]
                       (stall_cnt_q != 3'h0) ? 3'(stall_cnt_q - 3'h1) : 3'h0;

  assign arm_cnt_d = (wr_ctl & io.io_wdata[eac_pkg::CB_ARM]) ? 3'(eac_pkg::ARM_WIN_CYC) :
                     (arm_cnt_q != 3'h0) ? 3'(arm_cnt_q - 3'h1) : 3'h0; // [RULE11]

  // ----------------------------------------------------------------
  // core-side registers, cleared by the ordinary reset
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_q <= '0;
      rie_q  <= 1'b0;
    end else begin
      if (wr_lo && !busy_q) begin
        addr_q[7:0] <= io.io_wdata; // [RULE3]
      end
      if (wr_hi && !busy_q) begin
        addr_q[AW-1:8] <= io.io_wdata[AW-9:0]; // [RULE3]
      end
      if (wr_ctl) begin
        rie_q <= io.io_wdata[eac_pkg::CB_RIE];
      end
    end
  end

  // read strobe is never stored: the byte lands in the same edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_q <= 8'h00;
    end else if (rd_go) begin
      data_q <= mem_q[addr_q]; // [RULE1] [RULE15]
    end else if (wr_dat) begin
      data_q <= io.io_wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_cnt_q   <= 3'h0;
      arm_q       <= 1'b0;
      stall_cnt_q <= 3'h0;
      stall_q     <= 1'b0;
      rdata_q     <= 8'h00;
      irq_q       <= 1'b0;
    end else begin
      arm_cnt_q   <= arm_cnt_d;
      arm_q       <= (arm_cnt_d != 3'h0);
      stall_cnt_q <= stall_cnt_d;
      stall_q     <= (stall_cnt_d != 3'h0); // [RULE2] [RULE12]
      if (io.io_re) begin
        rdata_q <= rdata_d;
      end
      irq_q <= rie_q & ~busy_q; // [RULE14]
    end
  end

  // ----------------------------------------------------------------
  // programming engine: power-on reset clears it; the ordinary reset only reloads mode_q while idle
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      busy_q    <= 1'b0;
      tick_q    <= '0;
      op_addr_q <= '0;
      op_data_q <= 8'h00;
      op_mode_q <= 2'h0;
      mode_q    <= 2'h0;
    end else begin
      if (!presetn && !busy_q) begin
        mode_q <= eac_pkg::PM_ERASE_WRITE;
      end else if (wr_ctl && !busy_q) begin
        mode_q <= io.io_wdata[eac_pkg::CB_PM_LO +: 2];
      end
      if (wr_go) begin
        busy_q    <= 1'b1;
        tick_q    <= '0;
        op_addr_q <= addr_q;
        op_data_q <= data_q;
        op_mode_q <= mode_q;
      end else if (done) begin
        busy_q <= 1'b0; // [RULE12]
      end else if (busy_q && osc_tick) begin
        tick_q <= TW'(tick_q + 1'b1); // [RULE4] [RULE10]
      end
    end
  end

  // the array itself keeps its contents through every reset
  always_ff @(posedge pclk) begin
    if (done) begin
      mem_q[op_addr_q] <= new_byte; // [RULE10]
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign io.io_rdata   = rdata_q;
  assign io.core_stall = stall_q;
  assign io.ready_irq  = irq_q;
endmodule

// ### rtl/eac_host.sv
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/1ps
module eac_host #(
  parameter int AW = eac_pkg::ADDR_W
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // self-programming engine busy
  input  wire logic        self_program_busy,
  // storage controller register port
  eac_if.core              io
);
  typedef enum logic [3:0] {
    S_IDLE, S_POLL, S_CHK, S_SPM, S_ALO, S_AHI, S_DAT,
    S_ARM, S_WSTB, S_RSTB, S_RDAT, S_RCAP
  } eac_hstate_t;

  eac_hstate_t   st_q;
  logic          pready_q;
  logic          pslverr_q;
  logic [31:0]   prdata_q;
  logic [AW-1:0] addr_q;
  logic [7:0]    wbyte_q;
  logic [7:0]    rbyte_q;
  logic [1:0]    mode_q;
  logic          rie_q;
  logic          is_wr_q;
  logic          wbusy_q;
  logic          done_q;
  logic          we_q;
  logic          re_q;
  logic [1:0]    ioa_q;
  logic [7:0]    iod_q;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic        setup_end;
  logic        wr_acc;
  logic        idle;
  logic        hit;
  logic        go;
  logic [7:0]  ctl_base;
  logic [31:0] rd_mux;

  assign setup_end = psel & penable & ~pready_q;
  assign wr_acc    = psel & penable & pready_q & pwrite;
  assign idle      = (st_q == S_IDLE);
  assign hit       = (paddr == eac_pkg::REG_ADDR) | (paddr == eac_pkg::REG_DATA)
                   | (paddr == eac_pkg::REG_CFG) | (paddr == eac_pkg::REG_CMD)
                   | (paddr == eac_pkg::REG_STAT);
  assign rd_mux    = (paddr == eac_pkg::REG_ADDR) ? 32'(addr_q) :
                     (paddr == eac_pkg::REG_DATA) ? 32'(rbyte_q) :
                     (paddr == eac_pkg::REG_CFG)  ? 32'({rie_q, mode_q}) :
                     (paddr == eac_pkg::REG_STAT) ?
                       32'({done_q, self_program_busy, io.ready_irq, wbusy_q, ~idle}) :
                     32'h0000_0000;
  // the core is halted while stalled and never issues back to back
  assign go        = ~io.core_stall & ~we_q & ~re_q;
  assign ctl_base  = (8'(mode_q) << eac_pkg::CB_PM_LO) | (8'(rie_q) << eac_pkg::CB_RIE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q <= setup_end;
      if (setup_end) begin
        pslverr_q <= ~hit;
        prdata_q  <= pwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_q  <= '0;
      wbyte_q <= 8'h00;
      mode_q  <= 2'h0;
      rie_q   <= 1'b0;
    end else if (wr_acc && idle) begin
      if (paddr == eac_pkg::REG_ADDR) begin
        addr_q <= pwdata[AW-1:0];
      end
      if (paddr == eac_pkg::REG_DATA) begin
        wbyte_q <= pwdata[7:0];
      end
      if (paddr == eac_pkg::REG_CFG) begin
        mode_q <= pwdata[1:0];
        rie_q  <= pwdata[eac_pkg::CFG_RIE];
      end
    end
  end

  // ----------------------------------------------------------------
  // access sequencer, run without interruption
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q    <= S_IDLE;
      is_wr_q <= 1'b0;
      wbusy_q <= 1'b0;
      done_q  <= 1'b0;
      rbyte_q <= 8'h00;
      we_q    <= 1'b0;
      re_q    <= 1'b0;
      ioa_q   <= 2'h0;
      iod_q   <= 8'h00;
    end else begin
      we_q <= 1'b0;
      re_q <= 1'b0;
      case (st_q)
        S_IDLE: begin
          if (wr_acc && paddr == eac_pkg::REG_CMD &&
              (pwdata[eac_pkg::CMD_RD] || pwdata[eac_pkg::CMD_WR])) begin
            is_wr_q <= pwdata[eac_pkg::CMD_WR];
            done_q  <= 1'b0;
            st_q    <= S_POLL; // [RULE9]
          end
        end
        S_POLL: if (go) begin
          re_q  <= 1'b1;
          ioa_q <= eac_pkg::IO_CTRL;
          st_q  <= S_CHK;
        end
        S_CHK: if (go) begin
          wbusy_q <= io.io_rdata[eac_pkg::CB_WSTB];
          st_q    <= io.io_rdata[eac_pkg::CB_WSTB] ? S_POLL :
                     is_wr_q ? S_SPM : S_ALO; // [RULE5] [RULE6] [RULE7]
        end
        S_SPM: if (!self_program_busy) st_q <= S_ALO; // [RULE8]
        S_ALO: if (go) begin
          we_q  <= 1'b1;
          ioa_q <= eac_pkg::IO_ADDR_LO;
          iod_q <= addr_q[7:0];
          st_q  <= S_AHI;
        end
        S_AHI: if (go) begin
          we_q  <= 1'b1;
          ioa_q <= eac_pkg::IO_ADDR_HI;
          iod_q <= 8'(addr_q[AW-1:8]);
          st_q  <= is_wr_q ? S_DAT : S_RSTB;
        end
        S_DAT: if (go) begin
          we_q  <= 1'b1;
          ioa_q <= eac_pkg::IO_DATA;
          iod_q <= wbyte_q;
          st_q  <= S_ARM;
        end
        S_ARM: if (go) begin
          we_q  <= 1'b1;
          ioa_q <= eac_pkg::IO_CTRL;
          iod_q <= ctl_base | (8'h01 << eac_pkg::CB_ARM); // [RULE6]
          st_q  <= S_WSTB;
        end
        S_WSTB: if (go) begin
          we_q  <= 1'b1;
          ioa_q <= eac_pkg::IO_CTRL;
          iod_q <= ctl_base | (8'h01 << eac_pkg::CB_ARM) | (8'h01 << eac_pkg::CB_WSTB);
          done_q <= 1'b1;
          st_q  <= S_IDLE;
        end
        S_RSTB: if (go) begin
          we_q  <= 1'b1;
          ioa_q <= eac_pkg::IO_CTRL;
          iod_q <= ctl_base | (8'h01 << eac_pkg::CB_RSTB); // [RULE7]
          st_q  <= S_RDAT;
        end
        S_RDAT: if (go) begin
          re_q  <= 1'b1;
          ioa_q <= eac_pkg::IO_DATA;
          st_q  <= S_RCAP;
        end
        S_RCAP: if (go) begin
          rbyte_q <= io.io_rdata;
          done_q  <= 1'b1;
          st_q    <= S_IDLE;
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata      = prdata_q;
  assign pready      = pready_q;
  assign pslverr     = pslverr_q;
  assign io.io_we    = we_q;
  assign io.io_re    = re_q;
  assign io.io_addr  = ioa_q;
  assign io.io_wdata = iod_q;
endmodule

// ### rtl/eac_if.sv
`timescale 1ns/1ps
interface eac_if #(parameter int AW = eac_pkg::ADDR_W);
  logic       io_we;
  logic       io_re;
  logic [1:0] io_addr;
  logic [7:0] io_wdata;
  logic [7:0] io_rdata;
  logic       core_stall;
  logic       ready_irq;

  modport dev (
    input  io_we, io_re, io_addr, io_wdata,
    output io_rdata, core_stall, ready_irq
  );
  modport core (
    output io_we, io_re, io_addr, io_wdata,
    input  io_rdata, core_stall, ready_irq
  );
endinterface

// ### rtl/eac_pkg.sv
package eac_pkg;
  // ----------------------------------------------------------------
  // storage geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 9;
  localparam int DEPTH  = 512;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // ----------------------------------------------------------------
  // core-side i/o register selects and control bits
  // ----------------------------------------------------------------
  localparam logic [1:0] IO_ADDR_LO = 2'h0;
  localparam logic [1:0] IO_ADDR_HI = 2'h1;
  localparam logic [1:0] IO_DATA    = 2'h2;
  localparam logic [1:0] IO_CTRL    = 2'h3;
  localparam int CB_RSTB  = 0;
  localparam int CB_WSTB  = 1;
  localparam int CB_ARM   = 2;
  localparam int CB_RIE   = 3;
  localparam int CB_PM_LO = 4;

  typedef enum logic [1:0] {
    PM_ERASE_WRITE = 2'h0,
    PM_ERASE       = 2'h1,
    PM_WRITE       = 2'h2,
    PM_RSVD        = 2'h3
  } eac_mode_t;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int RD_STALL_CYC  = 4;
  localparam int WR_STALL_CYC  = 2;
  localparam int ARM_WIN_CYC   = 4;
  localparam int RC_ATOMIC_CYC = 26368;
  localparam int T_ATOMIC_US   = 3400;
  localparam int T_SPLIT_US    = 1800;
  localparam int RC_SPLIT_CYC  = RC_ATOMIC_CYC * T_SPLIT_US / T_ATOMIC_US;
  localparam int TICK_W        = 15;

  // ----------------------------------------------------------------
  // controller apb map
  // ----------------------------------------------------------------
  localparam int APB_AW = 12;
  localparam logic [11:0] REG_ADDR = 12'h000;
  localparam logic [11:0] REG_DATA = 12'h004;
  localparam logic [11:0] REG_CFG  = 12'h008;
  localparam logic [11:0] REG_CMD  = 12'h00C;
  localparam logic [11:0] REG_STAT = 12'h010;
  localparam int CMD_RD  = 0;
  localparam int CMD_WR  = 1;
  localparam int CFG_RIE = 2;
endpackage

// ### verif/eac_sva.sv
`timescale 1ns/1ps
module eac_sva (
  // clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // core register port
  input wire logic       io_we,
  input wire logic       io_re,
  input wire logic [1:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic       core_stall,
  input wire logic       ready_irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------------------------------
  // helper: length of the current stall
  // ----------------------------------------------------------------
  logic [3:0] stall_run_q;
  logic [3:0] stall_run_d;
  wire        ctrl_wr = io_we && (io_addr == eac_pkg::IO_CTRL);
  assign stall_run_d = core_stall ? stall_run_q + 4'h1 : 4'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stall_run_q <= 4'h0;
    end else begin
      stall_run_q <= stall_run_d;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_read_stall_four: assert property (
    ctrl_wr && io_wdata[eac_pkg::CB_RSTB] && !io_wdata[eac_pkg::CB_WSTB]
    |=> core_stall [*4] ##1 !core_stall) else $error("read stall not four cycles");
  a_write_stall_two: assert property (
    ctrl_wr && io_wdata[eac_pkg::CB_WSTB] |=> (core_stall [*2] ##1 !core_stall) or !core_stall)
    else $error("write stall not two cycles");
  a_stall_has_cause: assert property ($rose(core_stall) |-> $past(ctrl_wr))
    else $error("stall without control write");
  a_stall_run_bound: assert property (stall_run_q <= 4'h4)
    else $error("stall longer than four cycles");
  a_no_issue_stalled: assert property (core_stall |-> !io_we && !io_re)
    else $error("core access during stall");
  a_req_spacing_gap: assert property ((io_we || io_re) |=> !(io_we || io_re))
    else $error("core accesses on consecutive cycles");
  a_rdata_hold_value: assert property (!io_re |=> $stable(io_rdata))
    else $error("read data changed without read");
  a_ctrl_rstb_zero: assert property (
    io_re && io_addr == eac_pkg::IO_CTRL |=> !io_rdata[eac_pkg::CB_RSTB] && io_rdata[7:6] == 2'h0)
    else $error("read strobe or reserved bits read as one");

  c_read_stall: cover property (ctrl_wr && io_wdata[eac_pkg::CB_RSTB] ##1 core_stall [*4]);
  c_write_stall: cover property (ctrl_wr && io_wdata[eac_pkg::CB_WSTB] ##1 core_stall [*2]);
  c_irq_rise: cover property ($rose(ready_irq));
endmodule

// ### verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        pclk, presetn, por_n, osc_tick, tick_d, spb, hi_seen;
  logic        psel, penable, pwrite, pready, pslverr, rd_err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_q;
  logic [7:0]  mem [0:511];
  logic [8:0]  a;
  logic [7:0]  d;
  logic [1:0]  modes [0:4];
  integer      seed;
  int          n_mismatch, checks_done, tick_cnt, i;

  eac_if #(.AW(eac_pkg::ADDR_W)) bus ();
  eac_host eac_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .self_program_busy(spb), .io(bus));
  eac_device #(.ATOMIC_TICKS(8), .SPLIT_TICKS(4)) eac_device_inst (.pclk(pclk),
    .presetn(presetn), .por_n(por_n), .osc_tick(osc_tick), .io(bus));
  eac_sva eac_sva_inst (.pclk(pclk), .presetn(presetn), .io_we(bus.io_we), .io_re(bus.io_re),
    .io_addr(bus.io_addr), .io_wdata(bus.io_wdata), .io_rdata(bus.io_rdata),
    .core_stall(bus.core_stall), .ready_irq(bus.ready_irq));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // random oscillator ticks; count those landing while the ready line is low
  // after it has been seen high, so a disabled ready line counts nothing
  always @(posedge pclk) begin
    osc_tick <= ($random(seed) % 3 == 0);
    tick_d <= osc_tick;
    if (bus.ready_irq === 1'b1) hi_seen = 1'b1;
    if (hi_seen === 1'b1 && bus.ready_irq === 1'b0 && tick_d === 1'b1) tick_cnt++;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) n_mismatch++;
    rd_q = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_idle(input bit for_irq);
    int n;
    n = 0;
    do begin
      apb(1'b0, eac_pkg::REG_STAT, 32'h0);
      n++;
    end while (rd_q[0] !== 1'b0 && n < 300);
    // the ready line only drops two cycles after the sequence ends
    if (for_irq) begin
      repeat (3) @(posedge pclk);
      do begin
        apb(1'b0, eac_pkg::REG_STAT, 32'h0);
        n++;
      end while (rd_q[2] !== 1'b1 && n < 300);
    end
    if (n >= 300) n_mismatch++;
  endtask

  function automatic logic [7:0] exp_byte(input logic [7:0] o, input logic [7:0] v,
                                          input logic [1:0] m);
    case (m)
      2'h0: exp_byte = v;
      2'h1: exp_byte = 8'hFF;
      2'h2: exp_byte = o & v;
      default: exp_byte = o;
    endcase
  endfunction

  task automatic do_write(input logic [8:0] wa, input logic [7:0] wd, input logic [1:0] m);
    int n;
    n = (m == 2'h0) ? 8 : 4;
    apb(1'b1, eac_pkg::REG_CFG, {29'h0, 1'b1, m});
    apb(1'b1, eac_pkg::REG_ADDR, {23'h0, wa});
    apb(1'b1, eac_pkg::REG_DATA, {24'h0, wd});
    tick_cnt = 0;
    hi_seen = 1'b0;
    apb(1'b1, eac_pkg::REG_CMD, 32'h2);
    wait_idle(1'b1);
    if (m != 2'h3) chk(32'(tick_cnt >= n - 1 && tick_cnt <= n), 32'h1);
    chk(32'(rd_q[2]), 32'h1);
    mem[wa] = exp_byte(mem[wa], wd, m);
  endtask

  task automatic do_read(input logic [8:0] ra);
    apb(1'b1, eac_pkg::REG_ADDR, {23'h0, ra});
    apb(1'b1, eac_pkg::REG_CMD, 32'h1);
    wait_idle(1'b0);
    apb(1'b0, eac_pkg::REG_DATA, 32'h0);
    chk(rd_q, {24'h0, mem[ra]});
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 38287;
    {presetn, por_n, spb, psel, penable, pwrite} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    modes = '{2'h0, 2'h2, 2'h1, 2'h3, 2'h0};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
    apb(1'b0, eac_pkg::REG_STAT, 32'h0);
    chk(rd_q, 32'h0);
    apb(1'b0, eac_pkg::REG_CFG, 32'h0);
    chk(rd_q, 32'h0);
    apb(1'b0, 12'h014, 32'h0);
    chk({31'h0, rd_err}, 32'h1);
    $display("reset and map test done");
    a = 9'($random(seed));
    for (i = 0; i < 5; i++) begin
      d = 8'($random(seed));
      do_write(a, d, modes[i]);
      do_read(a);
    end
    $display("mode test done");
    for (i = 0; i < 6; i++) begin
      a = (i == 0) ? 9'h000 : (i == 1) ? 9'h1FF : 9'($random(seed));
      do_write(a, 8'($random(seed)), 2'h0);
      do_read(a);
    end
    $display("random write test done");
    spb <= 1'b1;
    apb(1'b1, eac_pkg::REG_CMD, 32'h2);
    apb(1'b1, eac_pkg::REG_ADDR, 32'h0);
    repeat (20) @(posedge pclk);
    chk(32'(bus.ready_irq), 32'h1);
    apb(1'b0, eac_pkg::REG_STAT, 32'h0);
    chk({28'h0, rd_q[3:0]}, 32'hD);
    spb <= 1'b0;
    wait_idle(1'b1);
    apb(1'b0, eac_pkg::REG_ADDR, 32'h0);
    chk(rd_q, {23'h0, a});
    mem[a] = exp_byte(mem[a], 8'($random(seed)), 2'h3);
    do_read(a);
    $display("self program test done");
    apb(1'b1, eac_pkg::REG_CFG, 32'h4);
    apb(1'b1, eac_pkg::REG_DATA, 32'h5A);
    apb(1'b1, eac_pkg::REG_CMD, 32'h2);
    wait_idle(1'b0);
    repeat (2) @(posedge pclk);
    chk(32'(bus.ready_irq), 32'h0);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    mem[a] = 8'h5A;
    do_read(a);
    $display("reset during write test done");
    tally_and_finish();
  end

  initial begin
    #1000000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule
